// ### led_fault_pkg.sv
// Shared constants for the LED fault status and gain configuration block
package led_fault_pkg;
  localparam int unsigned CHANNELS        = 16;
  localparam int unsigned CFG_WIDTH       = 16;
  localparam int unsigned CFG_MULT_BIT    = 0;
  localparam int unsigned CFG_EXP_BIT     = 1;
  localparam int unsigned CFG_MANT_LSB    = 2;
  localparam int unsigned CFG_MANT_WIDTH  = 6;
  localparam logic [7:0]  CFG_RESET_LOW   = 8'hff;
  localparam logic [15:0] CFG_RESET       = 16'h00ff;
  localparam logic [4:0]  RATIO_HIGH      = 5'h0f;
  localparam logic [4:0]  RATIO_LOW       = 5'h05;
  localparam int unsigned MANT_DENOM_LOG2 = 6;
  localparam int unsigned VG_DIV_LOG2     = 2;
  localparam int unsigned GAIN_FRAC_BITS  = 9;
  localparam int unsigned MODE_LATCH_EDGE = 4;
  localparam int unsigned STATUS_LOAD_LOW = 2;
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_SW1,
    MODE_SW2,
    MODE_SW3,
    MODE_SPECIAL
  } mode_t;
endpackage : led_fault_pkg

// ### gain_decode.sv
// Decoder of the configuration code into gain figures
`timescale 1ns/1ps
`default_nettype none
module gain_decode (
  input  wire logic [15:0] cfg_word,
  output logic      [9:0]  voltage_gain,
  output logic      [4:0]  current_ratio,
  output logic      [9:0]  total_current_gain
);
  logic       gain_exponent;
  logic [5:0] gain_mantissa;
  logic [5:0] d_value;
  logic [9:0] vg;
  logic [11:0] cg3;

  always_comb begin
    gain_exponent = cfg_word[led_fault_pkg::CFG_EXP_BIT];
    gain_mantissa = cfg_word[led_fault_pkg::CFG_MANT_LSB +: led_fault_pkg::CFG_MANT_WIDTH];
    // Mantissa bit 0 (config bit 2) is the most significant of D
    for (int i = 0; i < 6; i++) begin
      d_value[5 - i] = gain_mantissa[i];
    end
    // VG in units of 1/512: (1+exp) * (64+D) / 256
    vg = (10'({4'h1, d_value}) << gain_exponent) << 1;
    cg3 = 12'(vg);
    // Low multiplier divides by three; rounded down to the 1/512 grid
    if (cfg_word[led_fault_pkg::CFG_MULT_BIT]) begin
      current_ratio      = led_fault_pkg::RATIO_HIGH;
      total_current_gain = vg;
    end else begin
      current_ratio      = led_fault_pkg::RATIO_LOW;
      total_current_gain = 10'(cg3 / 12'd3);
    end
    voltage_gain = vg;
  end
endmodule : gain_decode
`default_nettype wire

// ### led_fault_status.sv
// Serial shift, mode switching, fault status capture and configuration latch
`timescale 1ns/1ps
`default_nettype none
module led_fault_status (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        serial_clk,
  input  wire logic        serial_in,
  input  wire logic        latch_strobe_sel,
  input  wire logic        drive_enable_detect_n,
  input  wire logic [15:0] current_ok,
  input  wire logic [15:0] short_trip,
  input  wire logic [15:0] short_release,
  input  wire logic        short_detect_variant,
  input  wire logic        global_overtemp,
  input  wire logic [15:0] channel_overtemp,
  output logic             serial_out,
  output logic      [15:0] channel_drive,
  output logic      [15:0] output_latch,
  output logic      [15:0] current_gain_config,
  output logic             special_mode,
  output logic      [9:0]  voltage_gain,
  output logic      [4:0]  current_ratio,
  output logic      [9:0]  total_current_gain
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]          clk_sync;
    logic [1:0]          din_sync;
    logic [1:0]          le_sync;
    logic [1:0]          oe_sync;
    logic [1:0]          gt_sync;
    logic [1:0]          var_sync;
    logic                special;
    logic [1:0][15:0]    ok_sync;
    logic [1:0][15:0]    st_sync;
    logic [1:0][15:0]    sr_sync;
    logic [1:0][15:0]    ct_sync;
    logic                clk_prev;
    logic [2:0]          oe_hist;
    logic [1:0]          low_cnt;
    led_fault_pkg::mode_t mode;
    logic [15:0]         shift;
    logic [15:0]         out_latch;
    logic [15:0]         cfg;
    logic [15:0]         fault_rec;
    logic [15:0]         short_state;
    logic [15:0]         drive;
    logic                sout;
    logic [9:0]          vg;
    logic [4:0]          ratio;
    logic [9:0]          cg;
  } state_t;

  state_t q, d;
  logic [9:0] vg_w;
  logic [4:0] ratio_w;
  logic [9:0] cg_w;
  logic       rise;
  logic       oe_n;
  logic       le;
  logic [15:0] status_word;
  logic [15:0] ok_c, st_c, sr_c, ct_c;

  gain_decode u_gain (
    .cfg_word           (q.cfg),
    .voltage_gain       (vg_w),
    .current_ratio      (ratio_w),
    .total_current_gain (cg_w)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    d = q;
    d.clk_sync = {q.clk_sync[0], serial_clk};
    d.din_sync = {q.din_sync[0], serial_in};
    d.le_sync  = {q.le_sync[0], latch_strobe_sel};
    d.oe_sync  = {q.oe_sync[0], drive_enable_detect_n};
    d.gt_sync  = {q.gt_sync[0], global_overtemp};
    // The variant strap is a pin as well, so it is synchronised like the rest
    d.var_sync = {q.var_sync[0], short_detect_variant};
    d.ok_sync  = {q.ok_sync[0], current_ok};
    d.st_sync  = {q.st_sync[0], short_trip};
    d.sr_sync  = {q.sr_sync[0], short_release};
    d.ct_sync  = {q.ct_sync[0], channel_overtemp};
    d.clk_prev = q.clk_sync[1];
    rise = q.clk_sync[1] & ~q.clk_prev;
    oe_n = q.oe_sync[1];
    le   = q.le_sync[1];
    ok_c = q.ok_sync[1];
    st_c = q.st_sync[1];
    sr_c = q.sr_sync[1];
    ct_c = q.ct_sync[1];

    // Shorted-load hysteresis, tracked only while the output is driven
    for (int n = 0; n < 16; n++) begin
      if (!q.drive[n]) begin
        d.short_state[n] = 1'b1;
      end else if (st_c[n]) begin
        d.short_state[n] = 1'b0;
      end else if (sr_c[n]) begin
        d.short_state[n] = 1'b1;
      end
    end

    // Over-temperature faults are sticky; set wins over the mode clear
    if (q.gt_sync[1]) begin
      d.fault_rec = 16'hffff;
    end else begin
      d.fault_rec = q.fault_rec | ct_c;
    end

    // Output enable low drives latched channels unless thermally shut down
    for (int n = 0; n < 16; n++) begin
      d.drive[n] = ~oe_n & q.out_latch[n] & ~q.gt_sync[1] & ~ct_c[n];
    end

    // Fault word: bit n is channel n
    for (int n = 0; n < 16; n++) begin
      status_word[n] = q.drive[n] & ok_c[n] & ~q.fault_rec[n]
                     & (~q.var_sync[1] | q.short_state[n]);
    end

    if (rise) begin
      d.oe_hist = {q.oe_hist[1:0], oe_n};
      d.sout    = q.shift[15];
      d.low_cnt = oe_n ? 2'h0 : (q.low_cnt == 2'h3 ? q.low_cnt : q.low_cnt + 2'h1);
      if (q.mode == led_fault_pkg::MODE_SPECIAL && !oe_n && q.low_cnt >= 2'(led_fault_pkg::STATUS_LOAD_LOW)) begin
        d.shift = status_word;
      end else begin
        d.shift = {q.shift[14:0], q.din_sync[1]};
      end
      // Mode switching on a one-clock low pulse of output enable
      case (q.mode)
        led_fault_pkg::MODE_SW1: d.mode = led_fault_pkg::MODE_SW2;
        led_fault_pkg::MODE_SW2: d.mode = led_fault_pkg::MODE_SW3;
        led_fault_pkg::MODE_SW3: begin
          if (le) begin
            d.mode = led_fault_pkg::MODE_SPECIAL;
          end else begin
            d.mode = led_fault_pkg::MODE_NORMAL;
            if (!q.gt_sync[1]) begin
              d.fault_rec = ct_c;
            end
          end
        end
        default: begin
          if ({q.oe_hist[1:0], oe_n} == 3'b101) begin
            d.mode = led_fault_pkg::MODE_SW1;
          end else if (le && q.mode == led_fault_pkg::MODE_SPECIAL) begin
            d.cfg = q.shift;
          end else if (le) begin
            d.out_latch = q.shift;
          end
        end
      endcase
    end
    d.special = (d.mode == led_fault_pkg::MODE_SPECIAL);
    d.vg    = vg_w;
    d.ratio = ratio_w;
    d.cg    = cg_w;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.mode <= led_fault_pkg::MODE_NORMAL;
      q.oe_hist <= 3'h7;
      q.cfg <= led_fault_pkg::CFG_RESET;
      q.short_state <= 16'hffff;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  always_comb begin
    serial_out          = q.sout;
    channel_drive       = q.drive;
    output_latch        = q.out_latch;
    current_gain_config = q.cfg;
    special_mode        = q.special;
    voltage_gain        = q.vg;
    current_ratio       = q.ratio;
    total_current_gain  = q.cg;
  end
endmodule : led_fault_status
`default_nettype wire

// ### led_fault_checker.sv
// Port checks for the fault status and gain block
`timescale 1ns/1ps
`default_nettype none
module led_fault_checker (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        global_overtemp,
  input wire logic [15:0] channel_overtemp,
  input wire logic [15:0] channel_drive,
  input wire logic [15:0] output_latch,
  input wire logic [15:0] current_gain_config,
  input wire logic        special_mode,
  input wire logic [9:0]  voltage_gain,
  input wire logic [4:0]  current_ratio,
  input wire logic [9:0]  total_current_gain
);
  // ----------------------------------------
  // Gain decode and output protection
  // ----------------------------------------
  logic [15:0] c;
  logic [9:0]  vg_exp;
  assign c = current_gain_config;
  // Mantissa bit 0 weighs most, so the field is read reversed
  assign vg_exp = c[1] ? {2'b01, c[2], c[3], c[4], c[5], c[6], c[7], 2'b00}
                       : {3'b001, c[2], c[3], c[4], c[5], c[6], c[7], 1'b0};
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence glob_hot_s;
    global_overtemp [*4];
  endsequence
  AST_CFG_RESET: assert property ($rose(rst_b) |-> c == led_fault_pkg::CFG_RESET)
    else $error("config not at default after reset");
  AST_VGAIN: assert property ($past(rst_b) |-> voltage_gain == $past(vg_exp))
    else $error("voltage gain wrong");
  AST_RATIO: assert property ($past(rst_b) |->
    current_ratio == ($past(c[0]) ? led_fault_pkg::RATIO_HIGH : led_fault_pkg::RATIO_LOW))
    else $error("current ratio wrong");
  AST_CGAIN: assert property ($past(rst_b) |->
    total_current_gain == ($past(c[0]) ? voltage_gain : voltage_gain / 10'h003))
    else $error("total gain wrong");
  AST_GLOBAL_OFF: assert property (glob_hot_s |=> channel_drive == 16'h0000)
    else $error("drive on during global trip");
  AST_CHAN_OFF: assert property ((channel_drive & $past(channel_overtemp) & $past(channel_overtemp, 2)
    & $past(channel_overtemp, 3) & $past(channel_overtemp, 4)) == 16'h0000)
    else $error("drive on during channel trip");
  AST_DRIVE_LATCH: assert property ((channel_drive & ~output_latch & ~$past(output_latch)) == 16'h0000)
    else $error("drive without latch");
  AST_CFG_HOLD: assert property (!special_mode && !$past(special_mode) |-> $stable(c))
    else $error("config written in normal mode");
  AST_LATCH_HOLD: assert property (special_mode && $past(special_mode) |-> $stable(output_latch))
    else $error("output latch written in special mode");
endmodule : led_fault_checker
`default_nettype wire

// ### host_link.sv
// Host side of the serial link: clock, data, strobe and enable
`timescale 1ns/1ps
`default_nettype none
module host_link (
  input  wire logic clock,
  output var logic  serial_clk,
  output var logic  serial_in,
  output var logic  latch_strobe_sel,
  output var logic  drive_enable_detect_n
);
  // ----------------------------------------
  // Bit, word and mode sequences
  // ----------------------------------------
  initial begin
    serial_clk = 1'b0;
    serial_in = 1'b0;
    latch_strobe_sel = 1'b0;
    drive_enable_detect_n = 1'b1;
  end
  // Clock stands low between bits; 800 ns per bit, entered at a falling edge
  task automatic rise(input logic d, le, oe_n);
    serial_in = d;
    latch_strobe_sel = le;
    drive_enable_detect_n = oe_n;
    repeat (4) @(negedge clock);
    serial_clk = 1'b1;
    repeat (4) @(negedge clock);
    serial_clk = 1'b0;
  endtask : rise
  task automatic send_word(input logic [15:0] w, input logic oe_n);
    for (int i = 15; i >= 0; i--) rise(w[i], 1'b0, oe_n);
  endtask : send_word
  // Strobe level held over three rises so either sampling point sees it
  task automatic mode(input logic le);
    rise(1'b0, 1'b0, 1'b1);
    rise(1'b0, 1'b0, 1'b0);
    rise(1'b0, 1'b0, 1'b1);
    repeat (3) rise(1'b0, le, 1'b1);
  endtask : mode
endmodule : host_link
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the fault status and gain block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clock, rst_b, serial_clk, serial_in, latch_strobe_sel, drive_enable_detect_n;
  logic        short_detect_variant, global_overtemp, serial_out, special_mode;
  logic [15:0] current_ok, short_trip, short_release, channel_overtemp, channel_drive;
  logic [15:0] output_latch, current_gain_config, lat, w, m;
  logic [15:0] tbl [4];
  logic [9:0]  voltage_gain, total_current_gain;
  logic [4:0]  current_ratio;
  int          bad_count, n_checks, c;
  led_fault_status u_dut (.clock, .rst_b, .serial_clk, .serial_in, .latch_strobe_sel, .drive_enable_detect_n,
    .current_ok, .short_trip, .short_release, .short_detect_variant, .global_overtemp, .channel_overtemp,
    .serial_out, .channel_drive, .output_latch, .current_gain_config, .special_mode, .voltage_gain,
    .current_ratio, .total_current_gain);
  host_link u_host (.clock, .serial_clk, .serial_in, .latch_strobe_sel, .drive_enable_detect_n);
  // ----------------------------------------
  // Checking tasks and model
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic gains(input logic [15:0] cf);
    int d, vg;
    d = {cf[2], cf[3], cf[4], cf[5], cf[6], cf[7]};
    vg = (1 + cf[1]) * (64 + d) * 2;
    chk(voltage_gain, 16'(vg), "vgain");
    chk(current_ratio, cf[0] ? 16'h000f : 16'h0005, "ratio");
    chk(total_current_gain, 16'(cf[0] ? vg : vg / 3), "cgain");
  endtask : gains
  // The strobe rise latches the word as it stood before that rise shifts
  task automatic strobe(input logic [15:0] wd, input logic sel, output logic [15:0] mm);
    logic [15:0] got;
    u_host.send_word(wd, 1'b1);
    u_host.rise(1'b0, 1'b1, 1'b1);
    repeat (3) @(negedge clock);
    got = sel ? current_gain_config : output_latch;
    mm = wd;
    chk(got, wd, "latch");
  endtask : strobe
  task automatic read_status(input logic [15:0] exp);
    logic [15:0] got;
    repeat (3) u_host.rise(1'b0, 1'b0, 1'b0);
    repeat (2) @(negedge clock);
    chk(channel_drive, lat, "drive");
    // Serial out shows the bit pushed out at each rise, so the word starts one rise later
    for (int i = 15; i >= 0; i--) begin
      u_host.rise(1'b0, 1'b0, 1'b1);
      got[i] = serial_out;
    end
    chk(got, exp, "status");
  endtask : read_status
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    {rst_b, short_detect_variant, global_overtemp} = 3'b000;
    {channel_overtemp, current_ok, short_trip, short_release} = {48'h0, 16'hffff};
    void'($urandom(32'hc3421653));
    repeat (4) @(negedge clock);
    rst_b = 1'b1;
    repeat (3) @(negedge clock);
    chk(current_gain_config, 16'h00ff, "cfg reset");
    gains(16'h00ff);
    u_host.mode(1'b1);
    repeat (3) @(negedge clock);
    chk(special_mode, 16'h0001, "special");
    tbl = '{16'h0000, 16'h0001, 16'hff02, 16'($urandom())};
    foreach (tbl[k]) begin
      strobe(tbl[k], 1'b1, m);
      gains(m);
    end
    u_host.mode(1'b0);
    repeat (3) @(negedge clock);
    chk(special_mode, 16'h0000, "normal");
    c = 1 + $urandom_range(14);
    current_ok = 16'($urandom());
    w = 16'($urandom()) | (16'h0003 << (c - 1));
    strobe(w, 1'b0, lat);
    repeat (2) u_host.rise(1'b0, 1'b0, 1'b0);
    channel_overtemp[c] = 1'b1;
    repeat (8) @(negedge clock);
    channel_overtemp = '0;
    repeat (8) @(negedge clock);
    u_host.mode(1'b1);
    read_status(lat & current_ok & ~(16'h0001 << c));
    global_overtemp = 1'b1;
    repeat (8) @(negedge clock);
    global_overtemp = 1'b0;
    repeat (8) @(negedge clock);
    read_status(16'h0000);
    u_host.mode(1'b0);
    u_host.mode(1'b1);
    short_detect_variant = 1'b1;
    short_trip = 16'h0001 << c;
    short_release = ~short_trip;
    read_status(lat & current_ok & ~short_trip);
    conclude();
  end
endmodule : tb_top
bind led_fault_status led_fault_checker u_chk (.clock, .rst_b, .global_overtemp, .channel_overtemp,
  .channel_drive, .output_latch, .current_gain_config, .special_mode, .voltage_gain, .current_ratio,
  .total_current_gain);
`default_nettype wire
